// ---- verilog/mud_decoder.sv ----
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mud_decoder
  import mud_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Micro-op requests
  input  wire logic        decode_op,
  input  wire logic        test_op,
  input  wire logic [7:0]  test_mask,
  input  wire logic [3:0]  src_field,
  // User machine state
  input  wire logic [15:0] user_instruction_word,
  input  wire logic [15:0] user_location_counter,
  input  wire logic        rr_format,
  input  wire logic [3:0]  dest_selector,
  input  wire logic [3:0]  src_selector,
  input  wire logic [15:0] user_dest_data,
  input  wire logic [15:0] user_src_data,
  input  wire logic [15:0] fixed_data,
  input  wire logic [15:0] program_status_word,
  input  wire logic [7:0]  micro_status_register,
  // Attention conditions
  input  wire logic        attention_request,
  input  wire logic        console_attention,
  input  wire logic        single_step_mode,
  input  wire logic        memory_parity_error,
  input  wire logic        power_fail_pending,
  // Decode ROM load port
  input  wire logic        rom_wr_en,
  input  wire logic [7:0]  rom_wr_addr,
  input  wire logic [15:0] rom_wr_data,
  // Sequencer outputs
  output var  logic        decode_done,
  output var  logic        decode_error,
  output var  logic        micro_addr_load,
  output var  logic [15:0] micro_address_low,
  output var  logic [15:0] micro_address_saved,
  output var  logic [15:0] micro_address_high,
  output var  logic        location_update,
  output var  logic [15:0] next_location,
  output var  logic        test_valid,
  output var  logic        test_taken,
  output var  logic [1:0]  decode_phase,
  output var  logic        source_flag,
  output var  logic [15:0] src_data
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic        busy;       // ROM read outstanding
    logic        done;
    logic        err;
    logic        ld;
    logic [15:0] ad_lo;
    logic [15:0] ad_sv;
    logic [15:0] ad_hi;
    logic        cnt_up;
    logic [15:0] cnt;
    logic        tv;
    logic        tt;
    mud_phase_e  phase;
    logic        sflag;
  } mud_state_s;

  mud_state_s  st;
  mud_state_s  next_st;
  logic [15:0] rom_data;
  logic        attn_any;
  logic        ix_zero;
  logic        both_cnt;
  logic [7:0]  mst_q;
  logic [15:0] cnt_plus;

  // Decode ROM, indexed by instruction bits 0-7
  mud_decode_rom #(
    .AW (ROM_AW),
    .DW (WORD_W)
  ) u_rom (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wr_en    (rom_wr_en),
    .wr_addr  (rom_wr_addr),
    .wr_data  (rom_wr_data),
    .rd_addr  (user_instruction_word[OPC_LSB +: ROM_AW]), // RULE1
    .rd_data  (rom_data)
  );

  // Operand selection for source fields E and F
  mud_src_select u_sel (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .src_field      (src_field),
    .source_flag    (st.sflag),
    .fixed_data     (fixed_data),
    .user_dest_data (user_dest_data),
    .user_src_data  (user_src_data),
    .src_data       (src_data)
  );

  // -------------------------------------------------------------------------
  // Conditions
  // -------------------------------------------------------------------------
  // Inputs must hold stable across the two-cycle decode
  assign attn_any = (attention_request & program_status_word[STS_ATTN_Q])
                  | console_attention | single_step_mode
                  | memory_parity_error | power_fail_pending;
  assign ix_zero  = (user_instruction_word[IX_HI:0] == 4'h0);
  assign both_cnt = (dest_selector == SEL_CNT) && (src_selector == SEL_CNT);
  // Counter wraps at the word size; the carry is dropped on purpose
  assign cnt_plus = 16'(user_location_counter + CNT_STEP);

  // Attention bit only counts when the status word allows it
  always_comb begin
    mst_q = micro_status_register;
    if (!program_status_word[STS_TEST_Q]) begin
      mst_q[MST_ATTN] = 1'b0; // RULE11
    end
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.done   = 1'b0;
    next_st.err    = 1'b0;
    next_st.ld     = 1'b0;
    next_st.cnt_up = 1'b0;
    next_st.tv     = 1'b0;
    next_st.tt     = 1'b0;
    if (test_op) begin
      next_st.tv = 1'b1;
      next_st.tt = |(mst_q & test_mask); // RULE10
    end
    if (decode_op && !st.busy) begin
      next_st.busy = 1'b1;  // Wait for the ROM word
    end else if (st.busy) begin
      next_st.busy = 1'b0;
      next_st.done = 1'b1;
      next_st.cnt  = user_location_counter;
      if (st.phase == MUD_PH2 || st.phase == MUD_PH3) begin
        if (!both_cnt) begin
          next_st.err = 1'b1; // RULE5
        end else if (!user_dest_data[DST15_POS]) begin
          next_st.cnt_up = 1'b1; // RULE6
          next_st.cnt    = cnt_plus;
        end else if (st.phase == MUD_PH3 || attn_any) begin
          next_st.ad_lo = DISP_ATTN; // RULE7
          next_st.sflag = 1'b0;      // RULE13
          next_st.phase = MUD_PH3;   // RULE15
          next_st.ld    = 1'b1;
        end else begin
          next_st.cnt_up = 1'b1;     // RULE8
          next_st.cnt    = cnt_plus;
          next_st.ad_lo  = DISP_PH0;
          next_st.sflag  = 1'b0;     // RULE13
          next_st.phase  = MUD_PH0;  // RULE15
          next_st.ld     = 1'b1;
        end
      end else if (rr_format) begin
        if (!both_cnt) begin
          next_st.err = 1'b1; // RULE2
        end else begin
          next_st.cnt_up = 1'b1; // RULE2
          next_st.cnt    = cnt_plus;
          next_st.ad_lo  = rom_data; // RULE1
          next_st.phase  = MUD_PH2;
          next_st.sflag  = 1'b1;     // RULE13
          next_st.ld     = 1'b1;
        end
      end else if (user_instruction_word[BIT0_POS]
                   || user_instruction_word[BIT3_POS]) begin
        next_st.ad_lo = ix_zero ? DISP_IX_Z : DISP_IX_NZ; // RULE3 RULE4
        next_st.ld    = 1'b1;
      end else if (ix_zero) begin
        next_st.ad_lo = DISP_RR_ZERO; // RULE3
        next_st.phase = MUD_PH1;      // RULE15
        next_st.sflag = (st.phase == MUD_PH0) ? 1'b1 : st.sflag; // RULE13
        next_st.ld    = 1'b1;
      end else begin
        next_st.ad_lo = rom_data; // RULE1
        next_st.ld    = 1'b1;
      end
      if (next_st.ld) begin
        next_st.ad_hi = ZERO_WORD;     // RULE9
        next_st.ad_sv = next_st.ad_lo; // RULE9
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{busy: 1'b0, done: 1'b0, err: 1'b0, ld: 1'b0,
              ad_lo: ZERO_WORD, ad_sv: ZERO_WORD, ad_hi: ZERO_WORD,
              cnt_up: 1'b0, cnt: ZERO_WORD, tv: 1'b0, tt: 1'b0,
              phase: MUD_PH0, sflag: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign decode_done         = st.done;
  assign decode_error        = st.err;
  assign micro_addr_load     = st.ld;
  assign micro_address_low   = st.ad_lo;
  assign micro_address_saved = st.ad_sv;
  assign micro_address_high  = st.ad_hi;
  assign location_update     = st.cnt_up;
  assign next_location       = st.cnt;
  assign test_valid          = st.tv;
  assign test_taken          = st.tt;
  assign decode_phase        = st.phase;
  assign source_flag         = st.sflag;

endmodule : mud_decoder
`default_nettype wire

// ---- shared/mud_pkg.sv ----
// Operation
// RULE1: Decode reads the dispatch value from the decode ROM at instruction bits 0-7.
// RULE2: Register-to-register path errors unless both selectors name the location counter.
// RULE3: Bit 0 or 3 set takes indexed path; zero bits 12-15 give 0004, phase 1.
// RULE4: Indexed path picks dispatch 000C or 0008 from the index field.
// RULE5: In phase 2 or 3, error unless both selectors name the location counter.
// RULE6: Phase 2 or 3 with destination bit 15 clear: counter plus 2, done.
// RULE7: Any attention condition gives dispatch 0014, clears source flag, sets phase 3.
// RULE8: No attention: counter plus 2, dispatch 0010, clear source flag, phase 0; code does this from phase 2 only, phase 3 keeps 0014 and stays 3.
// RULE9: Dispatch ends by clearing high address, loading saved and low addresses.
// RULE10: Test micro-op examines selected status bits and branches on the result.
// RULE11: Attention counts in test only when selected and status word bit 4 set.
// RULE12: Source field E or F reads the user destination or source register.
// RULE13: Source flag sets leaving phase 0, clears entering phase 0 or 3.
// RULE14: Source flag chooses between destination and source register for E and F.
// RULE15: Phase lives in a two-bit register changed only by decode paths.
package mud_pkg;

  // -------------------------------------------------------------------------
  // Widths and fields
  // -------------------------------------------------------------------------
  localparam int WORD_W     = 16;
  localparam int ROM_AW     = 8;
  localparam int ROM_DEPTH  = 256;
  localparam int OPC_LSB    = 8;   // Instruction bit 0 is the word's MSB
  localparam int IX_HI      = 3;   // Index field, bits 12-15 of instruction
  localparam int BIT0_POS   = 15;
  localparam int BIT3_POS   = 12;
  localparam int DST15_POS  = 0;   // Bit 15 in instruction numbering
  localparam int STS_ATTN_Q = 14;  // Program status bit 1
  localparam int STS_TEST_Q = 11;  // Program status bit 4
  localparam int MST_ATTN   = 5;

  // -------------------------------------------------------------------------
  // Dispatch values and constants
  // -------------------------------------------------------------------------
  localparam logic [15:0] DISP_RR_ZERO = 16'h0004;
  localparam logic [15:0] DISP_IX_NZ   = 16'h000C;
  localparam logic [15:0] DISP_IX_Z    = 16'h0008;
  localparam logic [15:0] DISP_PH0     = 16'h0010;
  localparam logic [15:0] DISP_ATTN    = 16'h0014;
  localparam logic [15:0] CNT_STEP     = 16'h0002;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [3:0]  SEL_CNT      = 4'hF;  // Names the location counter
  localparam logic [3:0]  SRC_DEST     = 4'hE;
  localparam logic [3:0]  SRC_SRC      = 4'hF;

  // Decode phase
  typedef enum logic [1:0] {
    MUD_PH0 = 2'h0,
    MUD_PH1 = 2'h1,
    MUD_PH3 = 2'h3,
    MUD_PH2 = 2'h2
  } mud_phase_e;

  // Decode outcomes
  typedef enum logic [1:0] {
    MUD_R_NONE  = 2'h0,
    MUD_R_DISP  = 2'h1,
    MUD_R_DONE  = 2'h3,
    MUD_R_ERROR = 2'h2
  } mud_result_e;

endpackage : mud_pkg

// ---- verilog/mud_decode_rom.sv ----
`timescale 1ns/100ps
`default_nettype none
module mud_decode_rom
  import mud_pkg::*;
#(
  parameter int AW = ROM_AW,
  parameter int DW = WORD_W
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Load port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // -------------------------------------------------------------------------
  // Storage; contents are loaded by the host, no reset on the array
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read so the dispatch value lands one cycle after the address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : mud_decode_rom
`default_nettype wire

// ---- verilog/mud_src_select.sv ----
`timescale 1ns/100ps
`default_nettype none
module mud_src_select
  import mud_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Selection
  input  wire logic [3:0]    src_field,
  input  wire logic          source_flag,
  input  wire logic [15:0]   fixed_data,
  input  wire logic [15:0]   user_dest_data,
  input  wire logic [15:0]   user_src_data,
  // Result
  output var  logic [15:0]   src_data
);

  // Fold E and F onto the user pair; the flag swaps which one each means
  function automatic logic [15:0] pick(input logic [3:0] f, input logic sf,
                                       input logic [15:0] fx,
                                       input logic [15:0] d,
                                       input logic [15:0] s);
    logic use_dest;
    use_dest = (f == SRC_DEST) ^ sf;
    if (f == SRC_DEST || f == SRC_SRC) begin
      pick = use_dest ? d : s; // RULE12 RULE14
    end else begin
      pick = fx;
    end
  endfunction : pick

  // Registered operand
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_data <= ZERO_WORD;
    end else begin
      src_data <= pick(src_field, source_flag, fixed_data,
                       user_dest_data, user_src_data);
    end
  end

endmodule : mud_src_select
`default_nettype wire

// ---- testbench/mud_decoder_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module mud_decoder_chk
  import mud_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Requests
  input wire logic        decode_op,
  input wire logic        test_op,
  input wire logic [15:0] user_location_counter,
  // Decode results
  input wire logic        decode_done,
  input wire logic        decode_error,
  input wire logic        micro_addr_load,
  input wire logic [15:0] micro_address_low,
  input wire logic [15:0] micro_address_saved,
  input wire logic [15:0] micro_address_high,
  input wire logic        location_update,
  input wire logic [15:0] next_location,
  input wire logic        test_valid,
  input wire logic [1:0]  decode_phase,
  input wire logic        source_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------------
  // Decode sequencing
  // ---------------------------------------------------------------------
  a_done_bound: assert property (decode_op |-> ##[1:3] decode_done)
    else $error("decode request not answered");
  a_load_addr: assert property (micro_addr_load |->
    micro_address_high == ZERO_WORD && micro_address_saved == micro_address_low)
    else $error("micro address load inconsistent");
  a_load_done: assert property (micro_addr_load |-> decode_done && !decode_error)
    else $error("address load outside a clean decode");
  a_error_quiet: assert property (decode_error |->
    decode_done && !micro_addr_load && !location_update)
    else $error("error decode changed state");
  a_attn_phase: assert property (micro_addr_load &&
    micro_address_low == DISP_ATTN |-> decode_phase == MUD_PH3 && !source_flag)
    else $error("attention dispatch with wrong phase");
  a_phase0_flag: assert property (decode_phase == MUD_PH0 |-> !source_flag)
    else $error("source flag set in phase 0");
  a_phase_hold: assert property ($changed(decode_phase) |-> decode_done)
    else $error("phase moved outside a decode");
  a_count_step: assert property (location_update |->
    next_location == user_location_counter + CNT_STEP)
    else $error("location counter step wrong");
  a_test_answer: assert property (test_op |=> test_valid)
    else $error("test not answered");

  // Main scenarios reached
  c_attn: cover property (micro_addr_load && micro_address_low == DISP_ATTN);
  c_error: cover property (decode_error);
  c_step_only: cover property (location_update && !micro_addr_load);
endmodule : mud_decoder_chk

bind mud_decoder mud_decoder_chk i_chk (.core_clk, .reset_n, .decode_op,
  .test_op, .user_location_counter, .decode_done, .decode_error,
  .micro_addr_load, .micro_address_low, .micro_address_saved,
  .micro_address_high, .location_update, .next_location, .test_valid,
  .decode_phase, .source_flag);
`default_nettype wire

// ---- testbench/mud_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mud_seq_model
  import mud_pkg::*;
#(
  parameter logic [15:0] COUNT_INIT = 16'h0100
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Write-back from the decoder
  input  wire logic        location_update,
  input  wire logic [15:0] next_location,
  // User machine state
  output logic [15:0]      user_location_counter
);
  // Counter takes the new value one edge after the pulse, so the
  // decoder sees the old count for the whole of its decode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      user_location_counter <= COUNT_INIT;
    end else if (location_update) begin
      user_location_counter <= next_location;
    end
  end
endmodule : mud_seq_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import mud_pkg::*;
;
  logic core_clk, reset_n, decode_op, test_op, rr_format, rom_wr_en;
  logic [7:0] test_mask, micro_status_register, rom_wr_addr;
  logic [3:0] src_field, dest_selector, src_selector;
  logic [15:0] user_instruction_word, user_location_counter, user_dest_data;
  logic [15:0] user_src_data, fixed_data, program_status_word, rom_wr_data;
  logic attention_request, console_attention, single_step_mode;
  logic memory_parity_error, power_fail_pending;
  logic decode_done, decode_error, micro_addr_load, location_update;
  logic test_valid, test_taken, source_flag;
  logic [15:0] micro_address_low, micro_address_saved, micro_address_high;
  logic [15:0] next_location, src_data;
  logic [1:0] decode_phase;
  int mismatches, n_checks;

  mud_decoder i_dut (.core_clk, .reset_n, .decode_op, .test_op, .test_mask,
    .src_field, .user_instruction_word, .user_location_counter, .rr_format,
    .dest_selector, .src_selector, .user_dest_data, .user_src_data,
    .fixed_data, .program_status_word, .micro_status_register,
    .attention_request, .console_attention, .single_step_mode,
    .memory_parity_error, .power_fail_pending, .rom_wr_en, .rom_wr_addr,
    .rom_wr_data, .decode_done, .decode_error, .micro_addr_load,
    .micro_address_low, .micro_address_saved, .micro_address_high,
    .location_update, .next_location, .test_valid, .test_taken,
    .decode_phase, .source_flag, .src_data);
  mud_seq_model i_seq (.core_clk, .reset_n, .location_update,
    .next_location, .user_location_counter);

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Reset, then load one decode table entry for opcode 42
  task automatic rst_load(input int n);
    reset_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rom_wr_en <= 1'b1;
    @(posedge core_clk);
    rom_wr_en <= 1'b0;
  endtask : rst_load

  // One decode; returns with the done pulse on the outputs
  task automatic dec(input logic [15:0] iw, output logic [15:0] cnt0);
    int i;
    @(posedge core_clk);
    #1;
    cnt0 = user_location_counter;
    @(posedge core_clk);
    user_instruction_word <= iw;
    decode_op <= 1'b1;
    @(posedge core_clk);
    decode_op <= 1'b0;
    for (i = 0; i < 4 && decode_done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (decode_done !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : dec

  task automatic t_rr();
    logic [15:0] l;
    rr_format <= 1'b1;
    dec(16'h4200, l);
    chk(micro_address_low, 16'h0123);
    chk(micro_address_saved, 16'h0123);
    chk(micro_address_high, ZERO_WORD);
    chk(next_location, l + CNT_STEP);
    chk(decode_phase, MUD_PH2);
    chk(source_flag, 1'b1);
    rr_format <= 1'b0;
    $display("done rr");
  endtask : t_rr

  task automatic t_p2();
    logic [15:0] l;
    dest_selector <= 4'h3;
    dec(16'h4200, l);
    chk(decode_error, 1'b1);
    dest_selector <= SEL_CNT;
    user_dest_data <= 16'hD000;
    dec(16'h4200, l);
    chk(location_update, 1'b1);
    chk(next_location, l + CNT_STEP);
    chk(micro_addr_load, 1'b0);
    chk(decode_phase, MUD_PH2);
    user_dest_data <= 16'hD001;
    attention_request <= 1'b1;
    dec(16'h4200, l);
    chk(micro_address_low, DISP_PH0);
    chk(next_location, l + CNT_STEP);
    chk(decode_phase, MUD_PH0);
    chk(source_flag, 1'b0);
    attention_request <= 1'b0;
    $display("done phase2");
  endtask : t_p2

  task automatic t_ix();
    logic [15:0] iw[5] = '{16'h8201, 16'h8200, 16'h1200, 16'h4201, 16'h4200};
    logic [15:0] ex[5] = '{16'h000C, 16'h0008, 16'h0008, 16'h0123, 16'h0004};
    logic [15:0] l;
    foreach (iw[k]) begin
      dec(iw[k], l);
      chk(micro_address_low, ex[k]);
    end
    chk(decode_phase, MUD_PH1);
    chk(source_flag, 1'b1);
    // Register-to-register with a foreign selector must refuse
    rr_format <= 1'b1;
    dest_selector <= 4'h3;
    dec(16'h4200, l);
    chk(decode_error, 1'b1);
    chk(micro_addr_load, 1'b0);
    chk(decode_phase, MUD_PH1);
    rr_format <= 1'b0;
    dest_selector <= SEL_CNT;
    $display("done indexed");
  endtask : t_ix

  // E and F pick user registers by the flag; other fields stay fixed
  task automatic t_src(input logic fl);
    logic [3:0] f[3] = '{4'hE, 4'hF, 4'h3};
    logic [15:0] ex[3];
    ex = '{fl ? 16'h3C3C : 16'hD001, fl ? 16'hD001 : 16'h3C3C, 16'h5A5A};
    foreach (f[k]) begin
      @(posedge core_clk);
      src_field <= f[k];
      @(posedge core_clk);
      #1;
      chk(src_data, ex[k]);
    end
    $display("done source select");
  endtask : t_src

  task automatic t_test();
    logic [7:0] m[4] = '{8'h20, 8'h20, 8'h01, 8'h01};
    logic [7:0] k8[4] = '{8'h20, 8'h20, 8'h01, 8'h02};
    logic [15:0] p[4] = '{16'h0000, 16'h0800, 16'h0000, 16'h0000};
    logic ex[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    foreach (m[k]) begin
      @(posedge core_clk);
      test_op <= 1'b1;
      micro_status_register <= m[k];
      test_mask <= k8[k];
      program_status_word <= p[k];
      @(posedge core_clk);
      test_op <= 1'b0;
      #1;
      chk(test_valid, 1'b1);
      chk(test_taken, ex[k]);
    end
    $display("done test op");
  endtask : t_test

  // Each attention source alone, always starting from phase 2
  task automatic t_attn();
    logic [15:0] l;
    program_status_word <= 16'h4000;
    for (int k = 0; k < 5; k++) begin
      rst_load(2);
      t_rr();
      {attention_request, console_attention, single_step_mode,
       memory_parity_error, power_fail_pending} <= 5'h10 >> k;
      dec(16'h4200, l);
      chk(micro_address_low, DISP_ATTN);
      chk(decode_phase, MUD_PH3);
      chk(source_flag, 1'b0);
      {attention_request, console_attention, single_step_mode,
       memory_parity_error, power_fail_pending} <= 5'h00;
    end
    // Phase 3 with a foreign selector errors; without attention stays 3
    dest_selector <= 4'h3;
    dec(16'h4200, l);
    chk(decode_error, 1'b1);
    dest_selector <= SEL_CNT;
    dec(16'h4200, l);
    chk(micro_address_low, DISP_ATTN);
    chk(decode_phase, MUD_PH3);
    $display("done attention");
  endtask : t_attn

  // Main sequence
  initial begin
    mismatches = 0;
    n_checks = 0;
    {reset_n, decode_op, test_op, rr_format, rom_wr_en} = 5'h00;
    {attention_request, console_attention, single_step_mode} = 3'h0;
    {memory_parity_error, power_fail_pending} = 2'h0;
    {test_mask, micro_status_register} = 16'h0000;
    {src_field, dest_selector, src_selector} = {4'h3, SEL_CNT, SEL_CNT};
    {user_instruction_word, program_status_word} = 32'h0000_0000;
    {user_dest_data, user_src_data, fixed_data} = 48'hD001_3C3C_5A5A;
    {rom_wr_addr, rom_wr_data} = 24'h42_0123;
    rst_load(16);
    t_rr();
    t_p2();
    t_ix();
    t_src(1'b1);
    t_test();
    t_attn();
    t_src(1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
